// >>> net_master.sv
// Operation
// - only this engine starts a transaction; slaves only answer its requests.
// - on the open variant, frames use rtu framing understood by all slaves; the engine adds no framing, only data bytes from memory.
// - port code sits in descriptor upper byte; f1 selects the bottom port.
// - slave number is the descriptor low byte, bcd 01 to 99.
// - up to 99 slaves on open variant, 90 on native variant.
// - byte count is bcd 1 to 128 for both reads and writes.
// - start address entered octal, converted to binary before use.
// - network write sends count bytes from local memory from start address.
// - network read stores count received bytes into memory from start address.
// - odd count changes only low 8 bits of the last 16-bit word.
// - native variant sends slave address unchanged as the slave's own; the engine sends no slave address, only data bytes from memory.
// - busy flag high from transaction start until the exchange completes.
// - error flag set whenever an error is detected during a transaction.
// - error flag cleared on every new read or write request.
// - one transaction per port at a time.
// - log an error when no answer arrives within the timeout.
`timescale 1ns/1ps
`include "net_master_regs.svh"

module net_master
   import net_master_pkg::*;
#(
   parameter int MEM_WORDS = 256,
   parameter int AW        = 8
)(
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   output logic      [7:0]  tx_data,
   output logic             tx_valid,
   output logic             tx_last,
   input  wire logic        tx_ready,
   input  wire logic [7:0]  rx_data,
   input  wire logic        rx_valid,
   input  wire logic        rx_error,
   output logic             port_busy_flag,
   output logic             port_comm_error_flag,
   output logic             irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      eng_state_t  st;
      request_t    req;
      logic [15:0] timeout;
      logic [15:0] tmr;
      logic [7:0]  total;
      logic [7:0]  idx;
      logic [AW-1:0] wptr;
      logic [AW-1:0] mem_addr;
      logic [1:0]  irq_st;
      logic [1:0]  irq_mask;
      logic        busy;
      logic        err;
      logic        irq;
      logic [15:0] rdata;
      logic [7:0]  tx_data;
      logic        tx_valid;
      logic        tx_last;
   } state_t;

   state_t s, next_s;
   logic [15:0] mem [MEM_WORDS];

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] bcd2bin(input logic [11:0] b);
      logic [9:0] v;
      v = 10'(b[11:8]) * 10'd100 + 10'(b[7:4]) * 10'd10 + 10'(b[3:0]);
      return v[7:0];
   endfunction

   function automatic logic bcd_ok(input logic [11:0] b);
      return (b[7:4] < 4'ha) && (b[3:0] < 4'ha) && (b[11:8] < 4'ha);
   endfunction

   // octal digits packed 3 bits each into a binary word
   function automatic logic [15:0] oct2bin(input logic [15:0] o);
      logic [15:0] r;
      r = {4'h0, o[14:12], o[10:8], o[6:4], o[2:0]};
      return r;
   endfunction

   logic [7:0]    slave_code;
   logic [7:0]    port_code;
   logic          desc_ok;
   logic [7:0]    slave_max;
   logic [AW-1:0] base;
   logic [15:0]   cur_word;
   logic          go;

   always_comb begin
      port_code  = s.req.port_slave[15:8];
      slave_code = s.req.port_slave[7:0];
      slave_max  = s.req.native_op ? `SLAVE_NATIVE_MAX
                                   : `SLAVE_BCD_MAX;
      desc_ok = (port_code == `PORT_CODE_BOTTOM)
              && bcd_ok({4'h0, slave_code})
              && slave_code >= `SLAVE_BCD_MIN && slave_code <= slave_max
              && bcd_ok(s.req.byte_count[11:0])
              && s.req.byte_count[11:0] >= `COUNT_BCD_MIN
              && s.req.byte_count[11:0] <= `COUNT_BCD_MAX;
      base     = AW'(oct2bin(s.req.start_addr));
      cur_word = mem[s.wptr];
      go       = wr && addr == `REG_COMMAND && wdata[`CMD_GO_BIT];
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s          = s;
      next_s.rdata    = `ZERO16;
      next_s.tx_valid = s.tx_valid && !tx_ready;
      next_s.tx_last  = s.tx_last && !tx_ready;

      if (wr) begin
         unique case (addr)
            `REG_PORT_SLAVE: if (!s.busy) next_s.req.port_slave = wdata;
            `REG_BYTE_COUNT: if (!s.busy) next_s.req.byte_count = wdata;
            `REG_START_ADDR: if (!s.busy) next_s.req.start_addr = wdata;
            `REG_TIMEOUT:    next_s.timeout = wdata;
            `REG_IRQ_MASK:   next_s.irq_mask = wdata[1:0];
            `REG_IRQ_STATUS: next_s.irq_st = s.irq_st & ~wdata[1:0];
            `REG_MEM_ADDR:   next_s.mem_addr = wdata[AW-1:0];
            default: ;
         endcase
      end
      if (rd) begin
         unique case (addr)
            `REG_PORT_SLAVE: next_s.rdata = s.req.port_slave;
            `REG_BYTE_COUNT: next_s.rdata = s.req.byte_count;
            `REG_START_ADDR: next_s.rdata = s.req.start_addr;
            `REG_STATUS:     next_s.rdata = {14'h0, s.err, s.busy};
            `REG_IRQ_STATUS: next_s.rdata = {14'h0, s.irq_st};
            `REG_IRQ_MASK:   next_s.rdata = {14'h0, s.irq_mask};
            `REG_TIMEOUT:    next_s.rdata = s.timeout;
            `REG_MEM_ADDR:   next_s.rdata = 16'(s.mem_addr);
            `REG_MEM_DATA:   next_s.rdata = mem[s.mem_addr];
            default:         next_s.rdata = `ZERO16;
         endcase
      end

      unique case (s.st)
         ST_IDLE: begin
            if (go) begin
               next_s.req.write_op  = wdata[`CMD_WRITE_BIT];
               next_s.req.native_op = wdata[`CMD_NATIVE_BIT];
               next_s.err  = 1'b0;
               next_s.busy = 1'b1;
               next_s.st   = ST_CHECK;
            end
         end
         ST_CHECK: begin
            next_s.total = bcd2bin(s.req.byte_count[11:0]);
            next_s.idx   = 8'h00;
            next_s.wptr  = base;
            next_s.tmr   = `ZERO16;
            if (!desc_ok) begin
               next_s.err = 1'b1;
               next_s.st  = ST_DONE;
            end else begin
               next_s.st = s.req.write_op ? ST_SEND : ST_WAIT;
            end
         end
         ST_SEND: begin
            // high byte first, then low byte of each word
            if (!s.tx_valid || tx_ready) begin
               next_s.tx_data  = s.idx[0] ? cur_word[7:0]
                                          : cur_word[15:8];
               next_s.tx_valid = 1'b1;
               next_s.tx_last  = (s.idx + 8'h01 == s.total);
               next_s.idx      = s.idx + 8'h01;
               if (s.idx[0])
                  next_s.wptr = s.wptr + AW'(1);
               if (s.idx + 8'h01 == s.total)
                  next_s.st = ST_WAIT;
            end
         end
         ST_WAIT, ST_RECV: begin
            next_s.tmr = s.tmr + 16'h0001;
            if (rx_error) begin
               next_s.err = 1'b1;
               next_s.st  = ST_DONE;
            end else if (s.tmr >= s.timeout) begin
               next_s.err = 1'b1;
               next_s.st  = ST_DONE;
            end else if (rx_valid) begin
               next_s.tmr = `ZERO16;
               if (s.req.write_op || s.idx == s.total) begin
                  next_s.st = ST_DONE;                             // ack
               end else begin
                  next_s.idx = s.idx + 8'h01;
                  if (s.idx[0])
                     next_s.wptr = s.wptr + AW'(1);
                  next_s.st = (s.idx + 8'h01 == s.total) ? ST_DONE
                                                          : ST_RECV;
               end
            end
         end
         ST_DONE: begin
            next_s.busy = 1'b0;
            next_s.st   = ST_IDLE;
            next_s.irq_st[`IRQ_DONE_BIT] = 1'b1;
            if (s.err)
               next_s.irq_st[`IRQ_ERR_BIT] = 1'b1;
         end
      endcase
      next_s.irq = |(next_s.irq_st & next_s.irq_mask);
   end

   // ----------------------------------------------------------------
   // local word memory: received bytes fill high then low byte, except an odd last byte, which fills the low byte
   // ----------------------------------------------------------------
   logic mem_we_hi;
   logic mem_we_lo;
   logic host_we;

   always_comb begin
      mem_we_hi = (s.st == ST_WAIT || s.st == ST_RECV) && !s.req.write_op
                && rx_valid && !rx_error && s.tmr < s.timeout
                && s.idx != s.total && !s.idx[0];
      mem_we_lo = (s.st == ST_WAIT || s.st == ST_RECV) && !s.req.write_op
                && rx_valid && !rx_error && s.tmr < s.timeout
                && s.idx != s.total && s.idx[0];
      host_we   = wr && addr == `REG_MEM_DATA;
   end

   always_ff @(posedge mclk) begin
      if (host_we)
         mem[s.mem_addr] <= wdata;
      else if (mem_we_hi && s.idx + 8'h01 == s.total)
         mem[s.wptr][7:0] <= rx_data;
      else if (mem_we_hi)
         mem[s.wptr][15:8] <= rx_data;
      else if (mem_we_lo)
         mem[s.wptr][7:0] <= rx_data;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s          <= '0;
         s.st       <= ST_IDLE;
         s.timeout  <= `TIMEOUT_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign rdata                = s.rdata;
   assign tx_data              = s.tx_data;
   assign tx_valid             = s.tx_valid;
   assign tx_last              = s.tx_last;
   assign port_busy_flag       = s.busy;
   assign port_comm_error_flag = s.err;
   assign irq                  = s.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_busy_on_go;
      @(posedge mclk) disable iff (!rstn)
      (go && !s.busy) |=> port_busy_flag;
   endproperty
   a_busy_on_go: assert property (p_busy_on_go)
      else $error("busy not raised on request");

   property p_err_clear;
      @(posedge mclk) disable iff (!rstn)
      (go && !s.busy) |=> !port_comm_error_flag;
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flag not cleared on request");

   property p_ignore_busy;
      @(posedge mclk) disable iff (!rstn)
      (go && s.busy && s.st != ST_DONE) |=> port_busy_flag
         && $stable(s.req.write_op);
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("request taken while busy");

   property p_timeout;
      @(posedge mclk) disable iff (!rstn)
      (s.st == ST_WAIT && !rx_valid && !rx_error && s.tmr >= s.timeout)
         |=> s.err ##1 !port_busy_flag;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout not flagged");

   property p_rx_err;
      @(posedge mclk) disable iff (!rstn)
      ((s.st == ST_WAIT || s.st == ST_RECV) && rx_error) |=> s.err;
   endproperty
   a_rx_err: assert property (p_rx_err)
      else $error("link error not flagged");

   property p_bad_port;
      @(posedge mclk) disable iff (!rstn)
      (s.st == ST_CHECK && port_code != `PORT_CODE_BOTTOM) |=> s.err;
   endproperty
   a_bad_port: assert property (p_bad_port)
      else $error("bad port code accepted");

   property p_tx_only_write;
      @(posedge mclk) disable iff (!rstn)
      tx_valid |-> s.req.write_op;
   endproperty
   a_tx_only_write: assert property (p_tx_only_write)
      else $error("send outside write");

   property p_done_idle;
      @(posedge mclk) disable iff (!rstn)
      (s.st == ST_DONE) |=> !port_busy_flag && s.st == ST_IDLE;
   endproperty
   a_done_idle: assert property (p_done_idle)
      else $error("busy not cleared at end");

   property p_no_tx_idle;
      @(posedge mclk) disable iff (!rstn)
      (s.st == ST_IDLE && !s.tx_valid) |=> !tx_valid;
   endproperty
   a_no_tx_idle: assert property (p_no_tx_idle)
      else $error("transmit started unrequested");

   property p_busy_hold;
      @(posedge mclk) disable iff (!rstn)
      (s.busy && s.st != ST_DONE) |=> port_busy_flag;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped mid transaction");

   property p_native_max;
      @(posedge mclk) disable iff (!rstn)
      (s.st == ST_CHECK && s.req.native_op
         && slave_code > `SLAVE_NATIVE_MAX) |=> s.err;
   endproperty
   a_native_max: assert property (p_native_max)
      else $error("slave above native limit accepted");

   property p_count_range;
      @(posedge mclk) disable iff (!rstn)
      (s.st == ST_CHECK && s.req.byte_count[11:0] > `COUNT_BCD_MAX)
         |=> s.err;
   endproperty
   a_count_range: assert property (p_count_range)
      else $error("byte count above limit accepted");

   // the odd last byte must leave the upper half of its word alone
   property p_odd_tail;
      @(posedge mclk) disable iff (!rstn)
      (mem_we_hi && !host_we && s.idx + 8'h01 == s.total)
         |=> mem[$past(s.wptr)][15:8] == $past(cur_word[15:8]);
   endproperty
   a_odd_tail: assert property (p_odd_tail)
      else $error("upper half of last word changed");

   property p_rx_store;
      @(posedge mclk) disable iff (!rstn)
      (mem_we_lo && !host_we)
         |=> mem[$past(s.wptr)][7:0] == $past(rx_data);
   endproperty
   a_rx_store: assert property (p_rx_store)
      else $error("received byte not stored");

endmodule // net_master

// >>> net_master_pkg.sv
package net_master_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_CHECK, ST_SEND, ST_WAIT, ST_RECV, ST_DONE
   } eng_state_t;

   typedef struct packed {
      logic [15:0] port_slave;
      logic [15:0] byte_count;
      logic [15:0] start_addr;
      logic        write_op;
      logic        native_op;
   } request_t;

   typedef struct packed {
      logic [7:0] data;
      logic       last;
   } link_byte_t;
endpackage

// >>> net_master_regs.svh
`ifndef NET_MASTER_REGS_SVH
`define NET_MASTER_REGS_SVH
// software register offsets (word index on the plain port)
`define REG_PORT_SLAVE   4'h0
`define REG_BYTE_COUNT   4'h1
`define REG_START_ADDR   4'h2
`define REG_COMMAND      4'h3
`define REG_STATUS       4'h4
`define REG_IRQ_STATUS   4'h5
`define REG_IRQ_MASK     4'h6
`define REG_TIMEOUT      4'h7
`define REG_MEM_ADDR     4'h8
`define REG_MEM_DATA     4'h9
// descriptor fields
`define PORT_CODE_BOTTOM 8'hf1
`define SLAVE_BCD_MIN    8'h01
`define SLAVE_BCD_MAX    8'h99
`define SLAVE_NATIVE_MAX 8'h90
`define COUNT_BCD_MIN    12'h001
`define COUNT_BCD_MAX    12'h128
// command bits
`define CMD_GO_BIT       0
`define CMD_WRITE_BIT    1
`define CMD_NATIVE_BIT   2
// status / irq bits
`define ST_BUSY_BIT      0
`define ST_ERR_BIT       1
`define IRQ_DONE_BIT     0
`define IRQ_ERR_BIT      1
// reset values
`define TIMEOUT_RESET    16'h0fa0
`define ZERO16           16'h0000
`endif

// >>> net_slave_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// slave station: absorbs frames, acks writes, sends reply bytes when the bench pulses burst_go
// ----------------------------------------------------------------
module net_slave_model (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   input  wire logic        tx_last,
   output logic             tx_ready,
   output logic      [7:0]  rx_data,
   output logic             rx_valid,
   output logic             rx_error,
   input  wire logic        ack_en,
   input  wire logic        slow,
   input  wire logic        burst_go,
   input  wire logic [2:0]  burst_len,
   input  wire logic [31:0] burst_bytes,
   input  wire logic        err_go,
   output logic      [31:0] seen,
   output logic      [15:0] seen_n,
   output logic      [15:0] last_n
);
   logic        phase;
   logic [2:0]  left;
   logic [1:0]  gap;
   logic [31:0] pend;

   // slow mode takes a byte only every other cycle
   assign tx_ready = !slow | phase;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         phase    <= 1'b0;
         left     <= 3'h0;
         gap      <= 2'h0;
         pend     <= 32'h0;
         seen     <= 32'h0;
         seen_n   <= 16'h0;
         last_n   <= 16'h0;
         rx_valid <= 1'b0;
         rx_data  <= 8'h00;
         rx_error <= 1'b0;
      end else begin
         phase    <= ~phase;
         // one-cycle line fault on the bench's request
         rx_error <= err_go;
         rx_valid <= 1'b0;
         // idle line keeps moving so a stale byte is never mistaken
         rx_data  <= ~rx_data;
         if (tx_valid && tx_ready) begin
            seen   <= {seen[23:0], tx_data};
            seen_n <= seen_n + 16'h1;
            if (tx_last) begin
               last_n <= seen_n + 16'h1;
               if (ack_en) begin
                  left <= 3'h1;
                  pend <= 32'h5a000000;
                  gap  <= 2'h3;
               end
            end
         end
         if (burst_go) begin
            left <= burst_len;
            pend <= burst_bytes;
            gap  <= 2'h3;
         end else if (left != 3'h0) begin
            if (gap != 2'h0) begin
               gap <= gap - 2'h1;
            end else begin
               rx_valid <= 1'b1;
               rx_data  <= pend[31:24];
               pend     <= {pend[23:0], 8'h00};
               left     <= left - 3'h1;
               gap      <= 2'h2;
            end
         end
      end
   end
endmodule // net_slave_model

// >>> tb_network_master_request_engine.sv
`timescale 1ns/1ps
`include "net_master_regs.svh"
module tb_network_master_request_engine;
   logic mclk, rstn, wr, rd, tx_valid, tx_last, tx_ready, rx_valid;
   logic rx_error, busy, err, irq, ack_en, slow, burst_go, err_go;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, seen_n, last_n, n0;
   logic [7:0] tx_data, rx_data;
   logic [2:0] burst_len;
   logic [31:0] burst_bytes, seen;
   int errors, comparisons, n;
   logic [32:0] tbl [9] = '{ // port/slave, count, error
      {16'hf101,16'h001,1'b0}, {16'hf199,16'h001,1'b0},
      {16'hf100,16'h001,1'b1}, {16'hf201,16'h001,1'b1},
      {16'hf11a,16'h001,1'b1}, {16'hf190,16'h005,1'b0},
      {16'hf101,16'h000,1'b1}, {16'hf101,16'h129,1'b1},
      {16'hf101,16'h128,1'b0}};

   net_master net_master_i (.mclk(mclk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_error(rx_error),
      .port_busy_flag(busy), .port_comm_error_flag(err), .irq(irq));
   net_slave_model net_slave_model_i (.mclk(mclk), .rstn(rstn),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_error(rx_error), .ack_en(ack_en), .slow(slow),
      .burst_go(burst_go), .burst_len(burst_len),
      .burst_bytes(burst_bytes), .seen(seen), .seen_n(seen_n),
      .last_n(last_n), .err_go(err_go));

   // ----------------------------------------------------------------
   // bus and check tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [15:0] e,
                        input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      check($sformatf("reg %h", a), e, rdata);
   endtask
   // busy must rise and error must clear right after each request
   task automatic go(input logic [15:0] cmd);
      wr_reg(`REG_COMMAND, cmd);
      #1;
      check("busy after go", 16'h1, {15'h0, busy});
      check("err after go", 16'h0, {15'h0, err});
   endtask
   task automatic wait_idle();
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check("busy", 16'h0, {15'h0, busy});
   endtask
   task automatic final_report();
      if (errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #(25 * 20000);
      errors++;
      final_report();
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      {rstn, wr, rd, ack_en, slow, burst_go, err_go} = 7'h00;
      {addr, wdata, burst_len, burst_bytes} = '0;
      errors = 0;
      comparisons = 0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      rd_chk(`REG_TIMEOUT, `TIMEOUT_RESET);
      rd_chk(`REG_STATUS, 16'h0);
      rd_chk(4'hf, 16'h0);
      wr_reg(`REG_TIMEOUT, 16'h0014);
      wr_reg(`REG_IRQ_MASK, 16'h0003);
      wr_reg(`REG_MEM_ADDR, 16'h000f);
      wr_reg(`REG_MEM_DATA, 16'ha1b2);
      wr_reg(`REG_MEM_ADDR, 16'h0010);
      wr_reg(`REG_MEM_DATA, 16'hc3d4);
      wr_reg(`REG_PORT_SLAVE, 16'hf105);
      wr_reg(`REG_BYTE_COUNT, 16'h0003);
      wr_reg(`REG_START_ADDR, 16'h0017);
      ack_en <= 1'b1;
      slow   <= 1'b1;
      n0 = seen_n;
      go(16'h0003);
      wr_reg(`REG_COMMAND, 16'h0001);
      wr_reg(`REG_START_ADDR, 16'h0000);
      wait_idle();
      check("tx hi", 16'ha1b2, seen[23:8]);
      check("tx lo", 16'h00c3, {8'h00, seen[7:0]});
      check("tx count", 16'h0003, seen_n - n0);
      check("tx last", seen_n, last_n);
      rd_chk(`REG_START_ADDR, 16'h0017);
      rd_chk(`REG_IRQ_STATUS, 16'h0001);
      check("irq done", 16'h1, {15'h0, irq});
      wr_reg(`REG_IRQ_STATUS, 16'h0001);
      #1;
      check("irq clr", 16'h0, {15'h0, irq});
      wr_reg(`REG_MEM_ADDR, 16'h0011);
      wr_reg(`REG_MEM_DATA, 16'hee00);
      wr_reg(`REG_START_ADDR, 16'h0020);
      slow <= 1'b0;
      go(16'h0001);
      burst_len   <= 3'h3;
      burst_bytes <= 32'h11223300;
      burst_go    <= 1'b1;
      @(posedge mclk);
      burst_go <= 1'b0;
      wait_idle();
      check("read err", 16'h0, {15'h0, err});
      wr_reg(`REG_MEM_ADDR, 16'h0010);
      rd_chk(`REG_MEM_DATA, 16'h1122);
      wr_reg(`REG_MEM_ADDR, 16'h0011);
      rd_chk(`REG_MEM_DATA, 16'hee33);
      go(16'h0001);
      err_go <= 1'b1;
      @(posedge mclk);
      err_go <= 1'b0;
      wait_idle();
      check("link err", 16'h1, {15'h0, err});
      ack_en <= 1'b0;
      wr_reg(`REG_START_ADDR, 16'h0017);
      go(16'h0003);
      wait_idle();
      if (n < 20) begin
         errors++;
         $display("MISMATCH timeout span expected 20 seen %0d", n);
      end
      comparisons++;
      check("timeout err", 16'h1, {15'h0, err});
      rd_chk(`REG_STATUS, 16'h0002);
      rd_chk(`REG_IRQ_STATUS, 16'h0003);
      ack_en <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         wr_reg(`REG_PORT_SLAVE, tbl[i][32:17]);
         wr_reg(`REG_BYTE_COUNT, tbl[i][16:1]);
         go(tbl[i][16:1] == 16'h001 && tbl[i][32:17] == 16'hf190 ?
            16'h0007 : 16'h0003);
         wait_idle();
         check("descriptor err", {15'h0, tbl[i][0]}, {15'h0, err});
      end
      wr_reg(`REG_PORT_SLAVE, 16'hf191);
      wr_reg(`REG_BYTE_COUNT, 16'h0001);
      go(16'h0007);
      wait_idle();
      check("native max", 16'h1, {15'h0, err});
      wr_reg(`REG_IRQ_MASK, 16'h0000);
      #1;
      check("irq masked", 16'h0, {15'h0, irq});
      wr_reg(`REG_IRQ_MASK, 16'h0002);
      #1;
      check("irq err", 16'h1, {15'h0, irq});
      wr_reg(`REG_IRQ_STATUS, 16'h0002);
      #1;
      check("irq err clr", 16'h0, {15'h0, irq});
      rd_chk(`REG_IRQ_STATUS, 16'h0001);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      check("err reset", 16'h0, {15'h0, err});
      check("irq reset", 16'h0, {15'h0, irq});
      rd_chk(`REG_TIMEOUT, `TIMEOUT_RESET);
      rd_chk(`REG_IRQ_STATUS, 16'h0000);
      final_report();
   end
endmodule // tb_network_master_request_engine
